// ---- rtl/mtu_timer_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module mtu_timer_unit (
  // Clock and reset.
  input  wire logic        REF_CLK_IN,
  input  wire logic        RESET_IN,
  input  wire logic        STANDBY_IN,
  // Internal 16-bit register bus.
  input  wire logic [7:0]  REG_ADDR_IN,
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  input  wire logic [15:0] REG_WDATA_IN,
  output logic      [15:0] REG_RDATA_OUT,
  // Capture pins.
  input  wire logic [3:0]  CAPTURE_PIN_IN,
  input  wire logic [17:0] GR_CAPTURE_PIN_IN,
  // Output pins and requests.
  output logic      [17:0] GR_COMPARE_PIN_OUT,
  output logic      [3:0]  PWM_PIN_OUT,
  output logic      [7:0]  ONESHOT_PIN_OUT,
  output logic      [3:0]  INTERVAL_IRQ_OUT,
  output logic      [3:0]  PWM_IRQ_OUT
);
  function automatic int gr_chan(input int i);
    return (i < 6) ? 0 : (i < 8) ? 1 : (i < 12) ? 2 : (i < 16) ? 3 : 4;
  endfunction : gr_chan

  function automatic logic is_period(input int i);
    return (i == 11) || (i == 15) || (i == 17);
  endfunction : is_period

  logic        rst;
  logic [9:0]  run_q;
  logic [4:0]  div_q;
  logic [2:0]  mode_q;
  logic [3:0]  tgs_q;
  logic [3:0]  ivl_en_q;
  logic [3:0]  ien_q;
  logic [3:0]  pm_flag_q;
  logic [7:0]  conn_q;
  logic [17:0] iomode_q;
  logic [2:0]  csel_q   [mtu_pkg::NUM_CSEL];
  logic [4:0]  ps1_q;
  logic [4:0]  ps2_q;
  logic        tick1;
  logic [5:0]  tick2;
  logic [10:0] ch_tick;
  logic [21:0] s1_q, s2_q, s3_q, filt_q, rise;
  logic [31:0] cnt0_q;
  logic [3:0]  ivl_prev_q;
  logic [31:0] cap_q    [4];
  logic [15:0] osb_q;
  logic [15:0] fr_q     [mtu_pkg::NUM_FR];
  logic [15:0] gr_q     [mtu_pkg::NUM_GR];
  logic [17:0] gr_match;
  logic [4:0]  pwm_on;
  logic [4:0]  per_match;
  logic [15:0] pw_cnt_q [mtu_pkg::NUM_PWM];
  logic [15:0] per_q    [mtu_pkg::NUM_PWM];
  logic [15:0] buf_q    [mtu_pkg::NUM_PWM];
  logic [15:0] dty_q    [mtu_pkg::NUM_PWM];
  logic [3:0]  pw_hit;
  logic [15:0] dc_q     [mtu_pkg::NUM_DC];
  logic [7:0]  dc_run_q;
  logic [15:0] rd_d;

  // Standby reinitialises the same state as reset.
  assign rst = RESET_IN | STANDBY_IN;

  // ==========================================================================
  // Control registers
  always_ff @(posedge REF_CLK_IN) begin
    if (rst) begin
      run_q    <= '0;
      div_q    <= '0;
      mode_q   <= '0;
      tgs_q    <= '0;
      ivl_en_q <= '0;
      ien_q    <= '0;
      conn_q   <= '0;
      iomode_q <= '0;
    end else if (REG_WR_IN) begin
      if (REG_ADDR_IN == mtu_pkg::ADR_START) run_q <= REG_WDATA_IN[9:0]; // [R19]
      if (REG_ADDR_IN == mtu_pkg::ADR_PSC) div_q <= REG_WDATA_IN[4:0];
      if (REG_ADDR_IN == mtu_pkg::ADR_MODE) mode_q <= REG_WDATA_IN[2:0];
      if (REG_ADDR_IN == mtu_pkg::ADR_TGS) tgs_q <= REG_WDATA_IN[3:0];
      if (REG_ADDR_IN == mtu_pkg::ADR_IVL) ivl_en_q <= REG_WDATA_IN[3:0];
      if (REG_ADDR_IN == mtu_pkg::ADR_IEN) ien_q <= REG_WDATA_IN[3:0];
      if (REG_ADDR_IN == mtu_pkg::ADR_CONN) conn_q <= REG_WDATA_IN[7:0];
      if (REG_ADDR_IN == mtu_pkg::ADR_IOM_LO) iomode_q[15:0] <= REG_WDATA_IN;
      if (REG_ADDR_IN == mtu_pkg::ADR_IOM_HI) iomode_q[17:16] <= REG_WDATA_IN[1:0];
    end
  end

  // ==========================================================================
  // Prescaler
  // A divisor lowered below the running count still ticks at once, not after a wrap.
  assign tick1 = (ps1_q >= div_q); // [R16]
  always_ff @(posedge REF_CLK_IN) begin
    if (rst) ps1_q <= '0;
    else ps1_q <= tick1 ? 5'h00 : ps1_q + 5'h01;
  end
  always_ff @(posedge REF_CLK_IN) begin
    if (rst) ps2_q <= '0;
    else if (tick1) ps2_q <= ps2_q + 5'h01;
  end
  assign tick2[0] = tick1;
  for (genvar k = 1; k < mtu_pkg::NUM_TICK; k++) begin : g_ps2
    assign tick2[k] = tick1 & (&ps2_q[k-1:0]); // [R17]
  end
  for (genvar c = 0; c < mtu_pkg::NUM_CSEL; c++) begin : g_csel
    localparam logic [7:0] A = 8'(mtu_pkg::ADR_CSEL + 2 * c);
    always_ff @(posedge REF_CLK_IN) begin
      if (rst) csel_q[c] <= '0;
      else if (REG_WR_IN && REG_ADDR_IN == A) csel_q[c] <= REG_WDATA_IN[2:0];
    end
    // Selections above five give no clock, so the channel stands still.
    assign ch_tick[c] = (csel_q[c] <= mtu_pkg::CSEL_MAX) ? tick2[csel_q[c]] : 1'b0; // [R18]
  end

  // ==========================================================================
  // Pin synchronisers
  assign rise = ~(s2_q ^ s3_q) & s3_q & ~filt_q;
  always_ff @(posedge REF_CLK_IN) begin
    if (rst) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      filt_q <= '0;
    end else begin
      s1_q <= {GR_CAPTURE_PIN_IN, CAPTURE_PIN_IN};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < mtu_pkg::NUM_PIN; i++) begin
        if (s2_q[i] == s3_q[i]) filt_q[i] <= s3_q[i];
      end
    end
  end

  // ==========================================================================
  // Channel 0
  always_ff @(posedge REF_CLK_IN) begin
    if (rst) cnt0_q <= '0;
    else if (tick1 && run_q[mtu_pkg::RUN_CH0]) cnt0_q <= cnt0_q + 32'h0000_0001; // [R8] [R21]
  end
  always_ff @(posedge REF_CLK_IN) begin
    if (rst) begin
      ivl_prev_q       <= '0;
      INTERVAL_IRQ_OUT <= '0;
    end else begin
      ivl_prev_q       <= cnt0_q[13:10];
      INTERVAL_IRQ_OUT <= ivl_en_q & cnt0_q[13:10] & ~ivl_prev_q; // [R9]
    end
  end
  for (genvar j = 0; j < 4; j++) begin : g_cap
    always_ff @(posedge REF_CLK_IN) begin
      if (rst) cap_q[j] <= '0;
      else if (tgs_q[j] ? gr_match[0] : rise[j]) cap_q[j] <= cnt0_q; // [R8]
    end
  end
  always_ff @(posedge REF_CLK_IN) begin
    if (rst) osb_q <= '0;
    else if (rise[0]) osb_q <= fr_q[0]; // [R11]
  end

  // ==========================================================================
  // Channels 1 to 5
  assign pwm_on    = {mode_q, 2'b00};
  assign per_match = {gr_match[17], gr_match[15], gr_match[11], 2'b00} & pwm_on; // [R12] [R13]
  for (genvar c = 0; c < mtu_pkg::NUM_FR; c++) begin : g_fr
    localparam logic [7:0] A = 8'(mtu_pkg::ADR_FRCNT + 2 * c);
    always_ff @(posedge REF_CLK_IN) begin
      if (rst) fr_q[c] <= '0;
      else if (REG_WR_IN && REG_ADDR_IN == A) fr_q[c] <= REG_WDATA_IN;
      else if (ch_tick[c] && run_q[c+1]) fr_q[c] <= per_match[c] ? 16'h0000 : fr_q[c] + 16'h0001; // [R12] [R21]
    end
  end
  for (genvar i = 0; i < mtu_pkg::NUM_GR; i++) begin : g_gr
    localparam int         C = gr_chan(i);
    localparam logic [7:0] A = 8'(mtu_pkg::ADR_GR + 2 * i);
    assign gr_match[i] = ch_tick[C] & run_q[C+1] & ~iomode_q[i] & (fr_q[C] == gr_q[i]); // [R10]
    always_ff @(posedge REF_CLK_IN) begin
      if (rst) gr_q[i] <= mtu_pkg::RST_ONES;
      else if (iomode_q[i] && rise[4+i]) gr_q[i] <= fr_q[C]; // [R10]
      else if (REG_WR_IN && REG_ADDR_IN == A) gr_q[i] <= REG_WDATA_IN;
    end
    always_ff @(posedge REF_CLK_IN) begin
      if (rst) GR_COMPARE_PIN_OUT[i] <= 1'b0;
      else if (pwm_on[C]) begin
        if (is_period(i)) GR_COMPARE_PIN_OUT[i] <= 1'b0;
        else if (per_match[C]) GR_COMPARE_PIN_OUT[i] <= 1'b1; // [R12] [R13]
        else if (gr_match[i]) GR_COMPARE_PIN_OUT[i] <= 1'b0;
      end else if (gr_match[i]) GR_COMPARE_PIN_OUT[i] <= ~GR_COMPARE_PIN_OUT[i];
    end
  end

  // ==========================================================================
  // Channels 6 to 9
  for (genvar p = 0; p < mtu_pkg::NUM_PWM; p++) begin : g_pwm
    localparam logic [7:0] A = 8'(mtu_pkg::ADR_PWM + mtu_pkg::PWM_STRIDE * p);
    logic step;
    assign step      = ch_tick[5+p] & run_q[mtu_pkg::RUN_PWM0+p]; // [R19] [R21]
    assign pw_hit[p] = step & (pw_cnt_q[p] == per_q[p]); // [R1]
    always_ff @(posedge REF_CLK_IN) begin
      if (rst) pw_cnt_q[p] <= '0;
      else if (REG_WR_IN && REG_ADDR_IN == 8'(A + mtu_pkg::PWM_OFS_CNT)) pw_cnt_q[p] <= REG_WDATA_IN;
      else if (pw_hit[p]) pw_cnt_q[p] <= mtu_pkg::PWM_RELOAD; // [R2]
      else if (step) pw_cnt_q[p] <= pw_cnt_q[p] + 16'h0001;
    end
    always_ff @(posedge REF_CLK_IN) begin
      if (rst) begin
        per_q[p] <= mtu_pkg::RST_ONES; // [R6]
        buf_q[p] <= mtu_pkg::RST_ONES; // [R6]
      end else if (REG_WR_IN) begin
        if (REG_ADDR_IN == 8'(A + mtu_pkg::PWM_OFS_PER)) per_q[p] <= REG_WDATA_IN; // [R7]
        if (REG_ADDR_IN == 8'(A + mtu_pkg::PWM_OFS_BUF)) buf_q[p] <= REG_WDATA_IN; // [R7]
      end
    end
    // The buffer transfer wins over a software write landing in the same cycle.
    always_ff @(posedge REF_CLK_IN) begin
      if (rst) dty_q[p] <= mtu_pkg::RST_ONES; // [R6]
      else if (pw_hit[p]) dty_q[p] <= buf_q[p]; // [R1]
      else if (REG_WR_IN && REG_ADDR_IN == 8'(A + mtu_pkg::PWM_OFS_DTY)) dty_q[p] <= REG_WDATA_IN; // [R7]
    end
    always_ff @(posedge REF_CLK_IN) begin
      if (rst) PWM_PIN_OUT[p] <= 1'b0;
      else if (pw_hit[p]) PWM_PIN_OUT[p] <= (buf_q[p] != 16'h0000); // [R2] [R5] [R22]
      else if (step && dty_q[p] == 16'h0000) PWM_PIN_OUT[p] <= 1'b0; // [R5]
      else if (step && dty_q[p] >= per_q[p]) PWM_PIN_OUT[p] <= 1'b1; // [R4]
      else if (step && pw_cnt_q[p] == dty_q[p]) PWM_PIN_OUT[p] <= 1'b0; // [R3]
    end
  end
  // Set wins over a clear written in the same cycle.
  always_ff @(posedge REF_CLK_IN) begin
    if (rst) pm_flag_q <= '0;
    else if (REG_WR_IN && REG_ADDR_IN == mtu_pkg::ADR_PSTAT) pm_flag_q <= (pm_flag_q & ~REG_WDATA_IN[3:0]) | pw_hit;
    else pm_flag_q <= pm_flag_q | pw_hit; // [R1]
  end
  always_ff @(posedge REF_CLK_IN) begin
    if (rst) PWM_IRQ_OUT <= '0;
    else PWM_IRQ_OUT <= pm_flag_q & ien_q; // [R20]
  end

  // ==========================================================================
  // Channel 10
  for (genvar d = 0; d < mtu_pkg::NUM_DC; d++) begin : g_dc
    localparam logic [7:0] A = 8'(mtu_pkg::ADR_DOWN_COUNTER + 2 * d);
    logic tick_d;
    logic start;
    assign tick_d = (d < 6) ? ch_tick[9] : ch_tick[10]; // [R18]
    assign start  = (REG_WR_IN && REG_ADDR_IN == mtu_pkg::ADR_DSTART && REG_WDATA_IN[d])
                  | (conn_q[d] & gr_match[d]); // [R15]
    always_ff @(posedge REF_CLK_IN) begin
      if (rst) dc_q[d] <= '0;
      else if (REG_WR_IN && REG_ADDR_IN == A) dc_q[d] <= REG_WDATA_IN;
      else if (dc_run_q[d] && tick_d && dc_q[d] != 16'h0000) dc_q[d] <= dc_q[d] - 16'h0001; // [R21]
    end
    // A start with a zero count produces no pulse.
    always_ff @(posedge REF_CLK_IN) begin
      if (rst) begin
        dc_run_q[d]        <= 1'b0;
        ONESHOT_PIN_OUT[d] <= 1'b0;
      end else if (!dc_run_q[d]) begin
        if (start && dc_q[d] != 16'h0000) begin
          dc_run_q[d]        <= 1'b1;
          ONESHOT_PIN_OUT[d] <= 1'b1; // [R14] [R15]
        end
      end else if (tick_d && dc_q[d] == 16'h0000) begin
        dc_run_q[d]        <= 1'b0;
        ONESHOT_PIN_OUT[d] <= 1'b0; // [R14]
      end
    end
  end

  // ==========================================================================
  // Read path
  always_comb begin
    logic [7:0] o;
    o    = '0;
    rd_d = '0;
    if (REG_ADDR_IN == mtu_pkg::ADR_START) rd_d = {6'h00, run_q};
    else if (REG_ADDR_IN == mtu_pkg::ADR_PSC) rd_d = {11'h000, div_q};
    else if (REG_ADDR_IN == mtu_pkg::ADR_MODE) rd_d = {13'h0000, mode_q};
    else if (REG_ADDR_IN == mtu_pkg::ADR_TGS) rd_d = {12'h000, tgs_q};
    else if (REG_ADDR_IN == mtu_pkg::ADR_IVL) rd_d = {12'h000, ivl_en_q};
    else if (REG_ADDR_IN == mtu_pkg::ADR_IEN) rd_d = {12'h000, ien_q};
    else if (REG_ADDR_IN == mtu_pkg::ADR_PSTAT) rd_d = {12'h000, pm_flag_q};
    else if (REG_ADDR_IN == mtu_pkg::ADR_DSTART) rd_d = {8'h00, dc_run_q};
    else if (REG_ADDR_IN == mtu_pkg::ADR_CONN) rd_d = {8'h00, conn_q};
    else if (REG_ADDR_IN == mtu_pkg::ADR_IOM_LO) rd_d = iomode_q[15:0];
    else if (REG_ADDR_IN == mtu_pkg::ADR_IOM_HI) rd_d = {14'h0000, iomode_q[17:16]};
    else if (REG_ADDR_IN == mtu_pkg::ADR_CNT0) rd_d = cnt0_q[15:0];
    else if (REG_ADDR_IN == 8'(mtu_pkg::ADR_CNT0 + 2)) rd_d = cnt0_q[31:16];
    else if (REG_ADDR_IN >= mtu_pkg::ADR_CAP && REG_ADDR_IN < mtu_pkg::ADR_OSB) begin
      o    = REG_ADDR_IN - mtu_pkg::ADR_CAP;
      rd_d = o[1] ? cap_q[o[3:2]][31:16] : cap_q[o[3:2]][15:0];
    end else if (REG_ADDR_IN == mtu_pkg::ADR_OSB) rd_d = osb_q;
    else if (REG_ADDR_IN >= mtu_pkg::ADR_CSEL && REG_ADDR_IN < 8'(mtu_pkg::ADR_CSEL + 2 * mtu_pkg::NUM_CSEL)) begin
      o    = REG_ADDR_IN - mtu_pkg::ADR_CSEL;
      rd_d = {13'h0000, csel_q[o[4:1]]};
    end else if (REG_ADDR_IN >= mtu_pkg::ADR_FRCNT && REG_ADDR_IN < 8'(mtu_pkg::ADR_FRCNT + 2 * mtu_pkg::NUM_FR)) begin
      o    = REG_ADDR_IN - mtu_pkg::ADR_FRCNT;
      rd_d = fr_q[o[3:1]];
    end else if (REG_ADDR_IN >= mtu_pkg::ADR_GR && REG_ADDR_IN < 8'(mtu_pkg::ADR_GR + 2 * mtu_pkg::NUM_GR)) begin
      o    = REG_ADDR_IN - mtu_pkg::ADR_GR;
      rd_d = gr_q[o[5:1]];
    end else if (REG_ADDR_IN >= mtu_pkg::ADR_PWM && REG_ADDR_IN < mtu_pkg::ADR_DOWN_COUNTER) begin
      o = REG_ADDR_IN - mtu_pkg::ADR_PWM;
      if (o[2:1] == 2'h0) rd_d = pw_cnt_q[o[4:3]];
      else if (o[2:1] == 2'h1) rd_d = per_q[o[4:3]]; // [R7]
      else if (o[2:1] == 2'h2) rd_d = buf_q[o[4:3]];
      else rd_d = dty_q[o[4:3]];
    end else if (REG_ADDR_IN >= mtu_pkg::ADR_DOWN_COUNTER && REG_ADDR_IN < 8'(mtu_pkg::ADR_DOWN_COUNTER + 2 * mtu_pkg::NUM_DC)) begin
      o    = REG_ADDR_IN - mtu_pkg::ADR_DOWN_COUNTER;
      rd_d = dc_q[o[3:1]];
    end
  end
  always_ff @(posedge REF_CLK_IN) begin
    if (rst) REG_RDATA_OUT <= '0;
    else if (REG_RD_IN) REG_RDATA_OUT <= rd_d;
  end

  // ==========================================================================
  // Assertions, channel 6 and channel 0 shown as representatives, plus channels 1, 7 to 9 and 10
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (rst);

  a_pwm_reload_one: assert property (pw_hit[0] && !REG_WR_IN |=> pw_cnt_q[0] == 16'h0001 && pm_flag_q[0]) // [R1] [R2]
    else $error("PWM counter did not reload with one on period match");
  a_pwm_duty_copy: assert property (pw_hit[0] |=> dty_q[0] == $past(buf_q[0])) // [R1]
    else $error("Buffer not copied to active duty on period match");
  a_pwm_pin_high: assert property (pw_hit[0] && buf_q[0] != 16'h0000 |=> PWM_PIN_OUT[0]) // [R2] [R22]
    else $error("PWM pin not high after period match");
  a_pwm_duty_low: assert property (!pw_hit[0] && g_pwm[0].step && pw_cnt_q[0] == dty_q[0]
                                   && dty_q[0] < per_q[0] |=> !PWM_PIN_OUT[0]) // [R3]
    else $error("PWM pin not low after duty match");
  a_pwm_full_duty: assert property (g_pwm[0].step && dty_q[0] >= per_q[0] && dty_q[0] != 16'h0000
                                    && buf_q[0] != 16'h0000 |=> PWM_PIN_OUT[0]) // [R4]
    else $error("Full duty did not hold the pin high");
  a_pwm_zero_duty: assert property (g_pwm[0].step && dty_q[0] == 16'h0000 && !(pw_hit[0] && buf_q[0] != 16'h0000)
                                    |=> !PWM_PIN_OUT[0]) // [R5]
    else $error("Zero duty did not hold the pin low");
  a_reset_ones: assert property (disable iff (1'b0) $past(rst) |-> per_q[1] == 16'hFFFF && buf_q[2] == 16'hFFFF
                                 && dty_q[3] == 16'hFFFF) // [R6]
    else $error("PWM registers not all ones after reset");
  a_capture_pin: assert property (rise[1] && !tgs_q[1] |=> cap_q[1] == $past(cnt0_q)) // [R8]
    else $error("Capture did not store channel 0 counter");
  a_interval_req: assert property (ivl_en_q[2] && cnt0_q[12] && !ivl_prev_q[2] |=> INTERVAL_IRQ_OUT[2]) // [R9]
    else $error("Interval request missing");
  a_twin_capture: assert property (rise[0] |=> osb_q == $past(fr_q[0])) // [R11]
    else $error("Offset base capture missed");
  a_oneshot_end: assert property (dc_run_q[0] && g_dc[0].tick_d && dc_q[0] == 16'h0000 |=> !ONESHOT_PIN_OUT[0]
                                  && !dc_run_q[0]) // [R14]
    else $error("One-shot pin not low after underflow");
  a_stop_holds: assert property (!run_q[mtu_pkg::RUN_PWM0] && !REG_WR_IN |=> $stable(pw_cnt_q[0])
                                 && $stable(PWM_PIN_OUT[0])) // [R19]
    else $error("Stopped PWM channel changed state");
  a_prescale_gap: assert property (tick1 && div_q == 5'h03 |=> !tick1 [*3] ##1 tick1) // [R16]
    else $error("Prescaler divide by four broken");
  a_pwm_irq: assert property (pm_flag_q[1] && ien_q[1] |=> PWM_IRQ_OUT[1]) // [R20]
    else $error("PWM interrupt request missing");

  c_pwm_period: cover property (pw_hit[0] ##[1:300] pw_hit[0]);
  c_oneshot: cover property (ONESHOT_PIN_OUT[0] ##[1:300] !ONESHOT_PIN_OUT[0]);
  c_capture: cover property (rise[0] && run_q[mtu_pkg::RUN_CH0]);
  c_pwm_mode: cover property (per_match[2]);
endmodule : mtu_timer_unit
`default_nettype wire

// ---- rtl/mtu_pkg.sv ----
// How it works
// R1: PWM channel period match sets flag, restarts counter, copies buffer into active duty.
// R2: On period match the PWM pin goes high and counter reloads with one.
// R3: Counter equal to nonzero active duty drives the PWM pin low.
// R4: Active duty at or above period keeps the PWM pin high.
// R5: Active duty of zero keeps the PWM pin low.
// R6: Period, buffer and duty registers reset to all ones on reset or standby.
// R7: Period, buffer and duty registers are 16-bit, read/write, word access only.
// R8: Channel 0 has 32-bit counter, four captures from pin or channel 1 match.
// R9: Enabled interval bits request an interrupt when counter bits 10 to 13 rise.
// R10: Channel 1 has six, channel 2 two, capture-or-compare general registers.
// R11: Channel 1 offset base register captures channel 1 counter on first capture pin.
// R12: Channels 3 and 4 in PWM mode: fourth register period, first three duties.
// R13: Channel 5 like channel 3; PWM mode uses first as duty, second period.
// R14: Channel 10 eight down-counters: start drives pin high, underflow stops and lowers it.
// R15: Coupled down-counter starts on channel 1 or 2 compare match.
// R16: First prescaler divides clock by 1 to 32 from a 5-bit value.
// R17: Second prescaler divides by two to powers 0 to 5, six clocks.
// R18: Channels 1 to 9 pick one clock; channel 10 picks two group clocks.
// R19: Counters run only while their run bit is set; stopping keeps output levels.
// R20: PWM period match requests an interrupt when its enable bit is set.
// R21: All counters advance only on their selected prescaler enable pulse.
// R22: Duty and period match in one cycle resolve as period, output high.
package mtu_pkg;
  localparam int          NUM_GR      = 18;
  localparam int          NUM_FR      = 5;
  localparam int          NUM_PWM     = 4;
  localparam int          NUM_DC      = 8;
  localparam int          NUM_PIN     = 22;
  localparam int          NUM_CSEL    = 11;
  localparam int          NUM_TICK    = 6;
  localparam logic [15:0] RST_ONES    = 16'hFFFF;
  localparam logic [15:0] PWM_RELOAD  = 16'h0001;
  localparam logic [2:0]  CSEL_MAX    = 3'h5;
  // Register byte addresses on the internal 16-bit bus.
  localparam logic [7:0]  ADR_START   = 8'h00;
  localparam logic [7:0]  ADR_PSC     = 8'h02;
  localparam logic [7:0]  ADR_MODE    = 8'h08;
  localparam logic [7:0]  ADR_TGS     = 8'h0A;
  localparam logic [7:0]  ADR_IVL     = 8'h0C;
  localparam logic [7:0]  ADR_IEN     = 8'h0E;
  localparam logic [7:0]  ADR_PSTAT   = 8'h10;
  localparam logic [7:0]  ADR_DSTART  = 8'h12;
  localparam logic [7:0]  ADR_CONN    = 8'h14;
  localparam logic [7:0]  ADR_IOM_LO  = 8'h16;
  localparam logic [7:0]  ADR_IOM_HI  = 8'h18;
  localparam logic [7:0]  ADR_CNT0    = 8'h20;
  localparam logic [7:0]  ADR_CAP     = 8'h24;
  localparam logic [7:0]  ADR_OSB     = 8'h34;
  localparam logic [7:0]  ADR_CSEL    = 8'h40;
  localparam logic [7:0]  ADR_FRCNT   = 8'h60;
  localparam logic [7:0]  ADR_GR      = 8'h70;
  localparam logic [7:0]  ADR_PWM     = 8'hA0;
  localparam logic [7:0]  ADR_DOWN_COUNTER    = 8'hC0;
  // Offsets inside one PWM channel window of eight bytes.
  localparam int          PWM_STRIDE  = 8;
  localparam int          PWM_OFS_CNT = 0;
  localparam int          PWM_OFS_PER = 2;
  localparam int          PWM_OFS_BUF = 4;
  localparam int          PWM_OFS_DTY = 6;
  // Run bit positions in the start register.
  localparam int          RUN_CH0     = 0;
  localparam int          RUN_PWM0    = 6;
endpackage : mtu_pkg

// ---- test/mtu_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ====================================================================
// Far-side pins: capture sources held idle, the PWM load counts rises on pwm_in[0] only.
module mtu_pin_model (
  // Clock and pins.
  input  wire logic        clk_in,
  input  wire logic [3:0]  pwm_in,
  output logic      [3:0]  cap_out,
  output logic      [17:0] gr_cap_out,
  output var int           rise_count
);
  logic [3:0] last_q  = 4'h0;
  int         count_q = 0;
  // Pulled-down inputs with nothing attached, so no stray captures.
  assign cap_out    = 4'h0;
  assign gr_cap_out = 18'h00000;
  assign rise_count = count_q;
  always_ff @(posedge clk_in) begin
    last_q <= pwm_in;
    if (pwm_in[0] && !last_q[0]) begin
      count_q <= count_q + 1;
    end
  end
endmodule : mtu_pin_model
`default_nettype wire

// ---- test/mtu_timer_unit_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
// ====================================================================
// Register and pin sequences for the dedicated PWM and one-shot units and the channel 0 interval request.
module mtu_timer_unit_bench;
  logic        clk = 1'b0, rst = 1'b1, stby = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0]  addr = 8'h00, a, one;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [17:0] gr_cap, cmp;
  logic [3:0]  cap, pwm, irq, ivl;
  logic        lvl;
  int          rises, hi, lo, n, err_count = 0, total_checks = 0;
  always #5 clk = ~clk;
  mtu_timer_unit i_dut (.REF_CLK_IN(clk), .RESET_IN(rst), .STANDBY_IN(stby), .REG_ADDR_IN(addr),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .CAPTURE_PIN_IN(cap),
    .GR_CAPTURE_PIN_IN(gr_cap), .GR_COMPARE_PIN_OUT(cmp), .PWM_PIN_OUT(pwm), .ONESHOT_PIN_OUT(one),
    .INTERVAL_IRQ_OUT(ivl), .PWM_IRQ_OUT(irq));
  mtu_pin_model i_load (.clk_in(clk), .pwm_in(pwm), .cap_out(cap), .gr_cap_out(gr_cap), .rise_count(rises));
  task automatic finish_test();
    if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One access per call; the strobe drops before the next call can raise it.
  task automatic bus(input logic [7:0] ad, input logic w, input logic [15:0] d);
    @(negedge clk);
    addr = ad;
    wr = w;
    rd = !w;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
  endtask : bus
  task automatic rdc(input string what, input logic [7:0] ad, input logic [15:0] exp);
    bus(ad, 1'b0, 16'h0000);
    chk(what, exp, rdata);
  endtask : rdc
  function automatic logic pin(input bit sel);
    return sel ? one[0] : pwm[0];
  endfunction : pin
  task automatic wait_lvl(input bit sel, input logic v);
    int k;
    k = 0;
    while (pin(sel) !== v) begin
      @(negedge clk);
      k++;
      if (k > 200) begin
        err_count++;
        $display("[ERR] pin level expected %b seen %b", v, pin(sel));
        finish_test();
      end
    end
  endtask : wait_lvl
  // A software one-shot is already high on return from its start write, and has no low phase to time.
  task automatic measure(input bit sel);
    if (!sel) wait_lvl(sel, 1'b0);
    wait_lvl(sel, 1'b1);
    hi = 0;
    lo = 0;
    while (pin(sel) === 1'b1 && hi < 200) begin
      @(negedge clk);
      hi++;
    end
    while (!sel && pin(sel) === 1'b0 && lo < 200) begin
      @(negedge clk);
      lo++;
    end
    if (hi >= 200 || lo >= 200) begin
      err_count++;
      $display("[ERR] pulse length expected below 200 seen %0d", hi + lo);
      finish_test();
    end
  endtask : measure
  task automatic hold(input string what, input logic v);
    repeat (20) begin
      @(negedge clk);
      chk(what, {15'h0000, v}, {15'h0000, pwm[0]});
    end
  endtask : hold
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    for (int p = 0; p < 4; p++) begin
      for (int o = 2; o <= 6; o += 2) begin
        a = 8'(mtu_pkg::ADR_PWM + p * mtu_pkg::PWM_STRIDE + o);
        rdc("pwm reg reset", a, mtu_pkg::RST_ONES);
        bus(a, 1'b1, 16'(16'hA5A0 + p * 8 + o));
        rdc("pwm reg word", a, 16'(16'hA5A0 + p * 8 + o));
      end
    end
    rdc("unmapped", 8'hFE, 16'h0000);
    @(negedge clk);
    stby = 1'b1;
    @(negedge clk);
    stby = 1'b0;
    rdc("standby period", 8'hA2, mtu_pkg::RST_ONES);
    rdc("standby duty", 8'hBE, mtu_pkg::RST_ONES);
    bus(8'(mtu_pkg::ADR_CSEL + 10), 1'b1, 16'h0000);
    bus(mtu_pkg::ADR_PSC, 1'b1, 16'h0000);
    bus(8'hA2, 1'b1, 16'h0005);
    bus(8'hA4, 1'b1, 16'h0002);
    bus(8'hA6, 1'b1, 16'h0002);
    bus(mtu_pkg::ADR_START, 1'b1, 16'h0040);
    measure(1'b0);
    chk("pwm high", 16'h0002, 16'(hi));
    chk("pwm low", 16'h0003, 16'(lo));
    rdc("period flag", mtu_pkg::ADR_PSTAT, 16'h0001);
    bus(mtu_pkg::ADR_IEN, 1'b1, 16'h0001);
    @(negedge clk);
    chk("pwm irq", 16'h0001, {12'h000, irq});
    bus(8'hA4, 1'b1, 16'h0004);
    measure(1'b0);
    chk("buffered high", 16'h0004, 16'(hi));
    chk("buffered low", 16'h0001, 16'(lo));
    rdc("duty copied", 8'hA6, 16'h0004);
    bus(8'hA4, 1'b1, 16'h0005);
    repeat (12) @(negedge clk);
    hold("full duty", 1'b1);
    bus(8'hA4, 1'b1, 16'h0000);
    repeat (12) @(negedge clk);
    hold("zero duty", 1'b0);
    bus(8'hA4, 1'b1, 16'h0002);
    measure(1'b0);
    bus(mtu_pkg::ADR_START, 1'b1, 16'h0000);
    n = rises;
    lvl = pwm[0];
    repeat (20) @(negedge clk);
    chk("stopped pin", {15'h0000, lvl}, {15'h0000, pwm[0]});
    chk("stopped edges", 16'(n), 16'(rises));
    bus(8'(mtu_pkg::ADR_CSEL + 18), 1'b1, 16'h0000);
    bus(mtu_pkg::ADR_DOWN_COUNTER, 1'b1, 16'h0002);
    bus(mtu_pkg::ADR_DSTART, 1'b1, 16'h0001);
    measure(1'b1);
    chk("oneshot width", 16'h0003, 16'(hi));
    bus(mtu_pkg::ADR_DOWN_COUNTER, 1'b1, 16'h0000);
    bus(mtu_pkg::ADR_DSTART, 1'b1, 16'h0001);
    repeat (5) @(negedge clk);
    chk("oneshot zero", 16'h0000, {8'h00, one});
    bus(mtu_pkg::ADR_DOWN_COUNTER, 1'b1, 16'h0002);
    bus(mtu_pkg::ADR_GR, 1'b1, 16'h0005);
    bus(mtu_pkg::ADR_CONN, 1'b1, 16'h0001);
    bus(mtu_pkg::ADR_START, 1'b1, 16'h0002);
    measure(1'b1);
    chk("coupled width", 16'h0003, 16'(hi));
    chk("compare toggle", 16'h0001, {15'h0000, cmp[0]});
    // Divide by four: counter bit 12 rises after 4096 ticks, 16382 to 16385 cycles after the start.
    bus(mtu_pkg::ADR_PSC, 1'b1, 16'h0003);
    bus(mtu_pkg::ADR_IVL, 1'b1, 16'h0004);
    bus(mtu_pkg::ADR_START, 1'b1, 16'h0001);
    n = 0;
    while (ivl[2] !== 1'b1 && n < 17000) begin
      @(negedge clk);
      n++;
    end
    total_checks++;
    if (n < 16380 || n > 16390) begin
      err_count++;
      $display("[ERR] interval request cycles expected 16384 seen %0d", n);
    end
    finish_test();
  end
endmodule : mtu_timer_unit_bench
`default_nettype wire
